// file: src/stm_pkg.sv
/*
 * Package for the 10-bit standard timer: register map, field positions,
 * reset values, mode encodings and the state record of the timer.
 * Assumes a 32-bit APB slave with byte registers in the low bits.
 */
package stm_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] STM_ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] STM_ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] STM_ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] STM_ADDR_CNT_HI = 8'h0C;
  localparam logic [7:0] STM_ADDR_MATCH_LO = 8'h10;
  localparam logic [7:0] STM_ADDR_MATCH_HI = 8'h14;
  localparam logic [7:0] STM_ADDR_STATUS = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int STM_C0_PAUSE = 7;
  localparam int STM_C0_ENABLE = 3;
  localparam int STM_C1_OC = 3;
  localparam int STM_C1_POL = 2;
  localparam int STM_C1_DPX = 1;
  localparam int STM_C1_CCLR = 0;
  localparam int STM_ST_AF = 0;
  localparam int STM_ST_PF = 1;

  localparam logic [7:0] STM_RESET_BYTE = 8'h00;
  localparam logic [9:0] STM_CNT_MAX = 10'h3FF;
  localparam logic [9:0] STM_CNT_ZERO = 10'h000;
  localparam logic [2:0] STM_RP_FULL = 3'h0;
  localparam logic [31:0] STM_RD_ZERO = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    STM_MODE_CMP = 2'h0,
    STM_MODE_CAP = 2'h1,
    STM_MODE_PWM = 2'h2,
    STM_MODE_TMR = 2'h3
  } stm_mode_e;

  localparam logic [1:0] STM_IO_00 = 2'h0;
  localparam logic [1:0] STM_IO_01 = 2'h1;
  localparam logic [1:0] STM_IO_10 = 2'h2;
  localparam logic [1:0] STM_IO_11 = 2'h3;

  // APB request group
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } stm_apb_req_s;

  // All timer state
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [9:0] count;
    logic [9:0] match;
    logic [7:0] wr_buf;
    logic [7:0] rd_buf;
    logic en_prev;
    logic pin;
    logic cap_prev;
    logic af;
    logic pf;
    logic [31:0] prdata;
    logic wait_done;
  } stm_state_s;

endpackage : stm_pkg

// file: src/stm_timer.sv
/*
 * 10-bit standard timer with compare-match, capture, PWM/single-pulse
 * and timer/counter modes, behind an APB slave.
 * Assumes the timer clock is the bus clock and all inputs are
 * synchronous to it.
 */
module stm_timer
  import stm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Timer pins
  input wire logic capture_input_pin_in,
  output logic timer_output_pin_out,
  output logic timer_output_pin_n_out
);

  stm_state_s st_reg;
  stm_state_s st_next;
  stm_apb_req_s req;

  assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
                 paddr: paddr_in, pwdata: pwdata_in};

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] r);
    return a == r;
  endfunction : addr_hit

  function automatic logic addr_mapped(input logic [7:0] a);
    return addr_hit(a, STM_ADDR_CTRL0) || addr_hit(a, STM_ADDR_CTRL1) ||
           addr_hit(a, STM_ADDR_CNT_LO) || addr_hit(a, STM_ADDR_CNT_HI) ||
           addr_hit(a, STM_ADDR_MATCH_LO) ||
           addr_hit(a, STM_ADDR_MATCH_HI) ||
           addr_hit(a, STM_ADDR_STATUS);
  endfunction : addr_mapped

  // ---------------------------------------------------------------
  // Decoded control fields
  // ---------------------------------------------------------------
  stm_mode_e mode;
  logic [1:0] pin_fn;
  logic [2:0] period_code;
  logic enable;
  logic pause;
  logic oc;
  logic pol;
  logic dpx;
  logic cclr;
  logic run;
  logic match_a;
  logic match_p;
  logic overflow;
  logic access;
  logic wr;
  logic rd;
  logic cap_edge;
  logic pwm_active;
  logic [9:0] duty_len;

  always_comb begin
    mode = stm_mode_e'(st_reg.ctrl1[7:6]);
    pin_fn = st_reg.ctrl1[5:4];
    oc = st_reg.ctrl1[STM_C1_OC];
    pol = st_reg.ctrl1[STM_C1_POL];
    dpx = st_reg.ctrl1[STM_C1_DPX];
    cclr = st_reg.ctrl1[STM_C1_CCLR];
    period_code = st_reg.ctrl0[2:0];
    enable = st_reg.ctrl0[STM_C0_ENABLE];
    pause = st_reg.ctrl0[STM_C0_PAUSE];
    // Counter advances only while on and not paused
    run = enable && !pause && st_reg.en_prev;
    // Match value zero never flags A; counter just overflows
    match_a = run && (st_reg.match != STM_CNT_ZERO) &&
              (st_reg.count == st_reg.match);
    // P hits at the last clock of the selected period of code times 128 clocks; code
    // zero stands for the full range, so P then coincides with overflow
    match_p = run && ((period_code == STM_RP_FULL) ?
              (st_reg.count == STM_CNT_MAX) :
              ((st_reg.count[9:7] == period_code - 3'h1) &&
               (st_reg.count[6:0] == 7'h7F)));
    overflow = run && (st_reg.count == STM_CNT_MAX);
    access = req.psel && req.penable;
    // Writes land only on the completing edge; reads are fetched one
    // cycle earlier so that prdata is registered when pready rises
    wr = access && req.pwrite && st_reg.wait_done;
    rd = access && !req.pwrite && !st_reg.wait_done;
    unique case (pin_fn)
      STM_IO_00: cap_edge = capture_input_pin_in && !st_reg.cap_prev;
      STM_IO_01: cap_edge = !capture_input_pin_in && st_reg.cap_prev;
      STM_IO_10: cap_edge = capture_input_pin_in != st_reg.cap_prev;
      STM_IO_11: cap_edge = 1'b0;
    endcase
    // The counter clear sets the period, so only the duty length is
    // needed here; the period code counts in 128-clock units
    duty_len = st_reg.match;
    if (dpx) begin
      duty_len = {period_code, 7'h00};
    end
    // Code zero as duty means the full 1024-clock range: always active
    pwm_active = (dpx && period_code == STM_RP_FULL) ||
                 (st_reg.count < duty_len);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.en_prev = enable;
    st_next.cap_prev = capture_input_pin_in;
    st_next.prdata = STM_RD_ZERO;
    st_next.wait_done = access && !st_reg.wait_done;
    // Flag clears come first, so a hardware set in the same cycle wins
    if (wr && addr_hit(req.paddr, STM_ADDR_STATUS)) begin
      st_next.af = st_reg.af && !req.pwdata[STM_ST_AF];
      st_next.pf = st_reg.pf && !req.pwdata[STM_ST_PF];
    end

    // Counter
    if (enable && !st_reg.en_prev) begin
      st_next.count = STM_CNT_ZERO;
      if (mode == STM_MODE_CMP) begin
        st_next.pin = oc;
      end
    end else if (run) begin
      unique case (mode)
        STM_MODE_CMP, STM_MODE_TMR: begin
          if (cclr) begin
            // Only A clears, and P raises no flag
            if (match_a || overflow) begin
              st_next.count = STM_CNT_ZERO;
            end else begin
              st_next.count = st_reg.count + 10'h001;
            end
          end else if (match_p || overflow) begin
            st_next.count = STM_CNT_ZERO;
          end else begin
            st_next.count = st_reg.count + 10'h001;
          end
          if (match_a) begin
            st_next.af = 1'b1;
          end
          if (match_p && !cclr) begin
            st_next.pf = 1'b1;
          end
          // Pin follows A matches only; P leaves it alone
          if (match_a && mode == STM_MODE_CMP) begin
            unique case (pin_fn)
              STM_IO_00: st_next.pin = st_reg.pin;
              STM_IO_01: st_next.pin = 1'b0;
              STM_IO_10: st_next.pin = 1'b1;
              STM_IO_11: st_next.pin = !st_reg.pin;
            endcase
          end
        end
        STM_MODE_CAP: begin
          // Clear select ignored: P match or overflow wraps
          if (match_p || overflow) begin
            st_next.count = STM_CNT_ZERO;
          end else begin
            st_next.count = st_reg.count + 10'h001;
          end
          if (match_p) begin
            st_next.pf = 1'b1;
          end
        end
        STM_MODE_PWM: begin
          if (pin_fn == STM_IO_11) begin
            // Single pulse: A match ends the pulse and turns off
            st_next.count = st_reg.count + 10'h001;
            if (match_a) begin
              st_next.af = 1'b1;
              st_next.ctrl0[STM_C0_ENABLE] = 1'b0;
            end
          end else begin
            // Period register clears the counter, swap-aware
            if ((dpx ? match_a : match_p) || overflow) begin
              st_next.count = STM_CNT_ZERO;
            end else begin
              st_next.count = st_reg.count + 10'h001;
            end
            if (match_a) begin
              st_next.af = 1'b1;
            end
            if (match_p) begin
              st_next.pf = 1'b1;
            end
          end
        end
      endcase
    end

    // Capture latches the live count into the match value
    if (mode == STM_MODE_CAP && enable && cap_edge) begin
      st_next.match = st_reg.count;
      st_next.af = 1'b1;
    end

    // Register writes; hardware flag sets win over clears
    if (wr) begin
      if (addr_hit(req.paddr, STM_ADDR_CTRL0)) begin
        st_next.ctrl0 = req.pwdata[7:0];
      end
      if (addr_hit(req.paddr, STM_ADDR_CTRL1)) begin
        st_next.ctrl1 = req.pwdata[7:0];
      end
      if (addr_hit(req.paddr, STM_ADDR_MATCH_LO)) begin
        st_next.wr_buf = req.pwdata[7:0];
      end
      if (addr_hit(req.paddr, STM_ADDR_MATCH_HI)) begin
        st_next.match = {req.pwdata[1:0], st_reg.wr_buf};
      end
    end

    // Reads; high byte read loads low byte into the read buffer
    if (rd) begin
      unique case (1'b1)
        addr_hit(req.paddr, STM_ADDR_CTRL0):
          st_next.prdata = {24'h000000, st_reg.ctrl0};
        addr_hit(req.paddr, STM_ADDR_CTRL1):
          st_next.prdata = {24'h000000, st_reg.ctrl1};
        addr_hit(req.paddr, STM_ADDR_CNT_HI): begin
          st_next.prdata = {30'h00000000, st_reg.count[9:8]};
          st_next.rd_buf = st_reg.count[7:0];
        end
        addr_hit(req.paddr, STM_ADDR_CNT_LO),
        addr_hit(req.paddr, STM_ADDR_MATCH_LO):
          st_next.prdata = {24'h000000, st_reg.rd_buf};
        addr_hit(req.paddr, STM_ADDR_MATCH_HI): begin
          st_next.prdata = {30'h00000000, st_reg.match[9:8]};
          st_next.rd_buf = st_reg.match[7:0];
        end
        addr_hit(req.paddr, STM_ADDR_STATUS):
          st_next.prdata = {30'h00000000, st_reg.pf, st_reg.af};
        default: st_next.prdata = STM_RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic pin_raw;
  logic pin_level;

  always_comb begin
    pin_raw = st_reg.pin;
    if (mode == STM_MODE_PWM) begin
      unique case (pin_fn)
        STM_IO_00: pin_raw = !oc;
        STM_IO_01: pin_raw = oc;
        STM_IO_10: pin_raw = (enable && pwm_active) ? oc : !oc;
        STM_IO_11: pin_raw = enable ? oc : !oc;
      endcase
    end
    // Timer/counter mode drives plain low; its pin is unused
    pin_level = (mode == STM_MODE_TMR) ? 1'b0 : (pin_raw ^ pol);
  end

  assign timer_output_pin_out = pin_level;
  assign timer_output_pin_n_out = !pin_level;
  assign prdata_out = st_reg.prdata;
  // Read data is registered, so every access takes one wait state
  assign pready_out = access && st_reg.wait_done;
  assign pslverr_out = pready_out && !addr_mapped(req.paddr);

endmodule : stm_timer

// file: bench/stm_timer_sva.sv
/*
 * Checker for the standard timer: APB handshake, read data, pin pair.
 * Sees only the ports of stm_timer and is attached by bind below.
 */
module stm_timer_sva
  import stm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Pins
  input wire logic timer_output_pin_out,
  input wire logic timer_output_pin_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  logic mapped;
  logic rd_done;
  logic hi_addr;
  assign mapped = (paddr_in[1:0] == 2'h0) && (paddr_in <= STM_ADDR_STATUS);
  assign rd_done = pready_out && !pwrite_in;
  assign hi_addr = (paddr_in == STM_ADDR_CNT_HI) ||
                   (paddr_in == STM_ADDR_MATCH_HI);

  sequence setup_s;
    psel_in && !penable_in;
  endsequence
  sequence access_s;
    psel_in && penable_in;
  endsequence

  AST_ONE_WAIT: assert property (
    setup_s ##1 access_s |-> !pready_out ##1 pready_out)
    else $error("access phase did not end after one wait");
  AST_READY_IN_ACCESS: assert property (
    pready_out |-> psel_in && penable_in)
    else $error("ready outside an access phase");
  AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  AST_ERR_UNMAPPED: assert property (pready_out && !mapped |-> pslverr_out)
    else $error("unmapped access not refused");
  AST_NO_ERR_MAPPED: assert property (pready_out && mapped |-> !pslverr_out)
    else $error("mapped access refused");
  AST_UNMAPPED_ZERO: assert property (
    rd_done && !mapped |-> prdata_out == STM_RD_ZERO)
    else $error("unmapped read not zero");
  AST_HI_UPPER: assert property (
    rd_done && hi_addr |-> prdata_out[31:2] == 30'h0)
    else $error("high byte read has upper bits set");
  AST_BYTE_UPPER: assert property (
    rd_done && mapped |-> prdata_out[31:8] == 24'h0)
    else $error("byte register read wider than a byte");
  AST_PIN_PAIR: assert property (
    timer_output_pin_n_out == !timer_output_pin_out)
    else $error("output pin pair not complementary");
endmodule : stm_timer_sva

bind stm_timer stm_timer_sva chk_u (.core_clk_in, .nrst_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out,
  .pslverr_out, .timer_output_pin_out, .timer_output_pin_n_out);

// file: bench/tb.sv
/*
 * Self-checking bench for stm_timer, driving APB and the capture pin.
 * Assumes one 100 MHz clock and the register map of stm_pkg.
 */
module tb
  import stm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic cap_pin = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, pin, pin_n, err;
  logic [31:0] rd;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  stm_timer dut_u (.core_clk_in(core_clk), .nrst_in(nrst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .capture_input_pin_in(cap_pin),
    .timer_output_pin_out(pin), .timer_output_pin_n_out(pin_n));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'(($urandom() & 32'h0000_0100) << 8), d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // High byte first: it latches the low byte for the second read
  task automatic rd10(input logic [7:0] hi, output logic [9:0] v);
    apb(1'b0, hi, 8'h00);
    v[9:8] = rd[1:0];
    apb(1'b0, hi - 8'h04, 8'h00);
    v[7:0] = rd[7:0];
  endtask : rd10

  task automatic wr10(input logic [9:0] v);
    apb(1'b1, STM_ADDR_MATCH_LO, v[7:0]);
    apb(1'b1, STM_ADDR_MATCH_HI, {6'h00, v[9:8]});
  endtask : wr10

  task automatic restart(input logic [7:0] c1, input logic [7:0] c0);
    apb(1'b1, STM_ADDR_CTRL0, 8'h00);
    apb(1'b1, STM_ADDR_CTRL1, c1);
    apb(1'b1, STM_ADDR_STATUS, 8'h03);
    apb(1'b1, STM_ADDR_CTRL0, c0);
  endtask : restart

  function automatic logic cmp_pin(input logic [1:0] io, input logic oc,
                                   input logic pol);
    logic lvl;
    case (io)
      STM_IO_01: lvl = 1'b0;
      STM_IO_10: lvl = 1'b1;
      STM_IO_11: lvl = ~oc;
      default: lvl = oc;
    endcase
    return lvl ^ pol;
  endfunction : cmp_pin

  function automatic logic cap_hit(input logic [1:0] io, input logic rise);
    return (io == STM_IO_00 && rise) || (io == STM_IO_01 && !rise) ||
           (io == STM_IO_10);
  endfunction : cap_hit

  initial begin
    logic [9:0] m;
    logic [9:0] c;
    logic [9:0] c2;
    logic [7:0] c1;
    void'($urandom(32'h20c6));
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    for (int a = 0; a <= 28; a += 4) begin
      apb(1'b0, 8'(a), 8'h00);
      chk("reset read", 32'h0, rd);
      chk("slverr", {31'h0, a == 28}, {31'h0, err});
    end
    apb(1'b1, STM_ADDR_CNT_LO, 8'hA5);
    rd10(STM_ADDR_CNT_HI, c);
    chk("count read only", 32'h0, {22'h0, c});
    c1 = 8'($urandom());
    apb(1'b1, STM_ADDR_CTRL1, c1);
    apb(1'b0, STM_ADDR_CTRL1, 8'h00);
    chk("ctrl1", {24'h0, c1}, rd);
    m = 10'($urandom_range(1023, 1));
    apb(1'b1, STM_ADDR_MATCH_LO, m[7:0]);
    rd10(STM_ADDR_MATCH_HI, c);
    chk("low byte buffered", 32'h0, {22'h0, c});
    apb(1'b1, STM_ADDR_MATCH_HI, {6'h00, m[9:8]});
    rd10(STM_ADDR_MATCH_HI, c);
    chk("match value", {22'h0, m}, {22'h0, c});
    $display("registers test done");
    for (int k = 0; k < 8; k++) begin
      logic oc;
      oc = 1'($urandom());
      m = 10'($urandom_range(60, 8));
      apb(1'b1, STM_ADDR_CTRL0, 8'h00);
      wr10(m);
      restart({2'b00, 2'(k), oc, k[2], 2'b01}, 8'h08);
      @(posedge core_clk);
      @(negedge core_clk);
      chk("initial pin", {31'h0, oc ^ k[2]}, {31'h0, pin});
      repeat (m + m / 2) @(posedge core_clk);
      @(negedge core_clk);
      chk("match pin", {31'h0, cmp_pin(2'(k), oc, k[2])}, {31'h0, pin});
      apb(1'b0, STM_ADDR_STATUS, 8'h00);
      chk("a flag only", 32'h1, rd);
    end
    $display("compare test done");
    apb(1'b1, STM_ADDR_CTRL0, 8'h00);
    wr10(10'h3E8);
    restart(8'h00, 8'h09);
    repeat (200) @(posedge core_clk);
    apb(1'b0, STM_ADDR_STATUS, 8'h00);
    chk("p flag", 32'h2, rd);
    apb(1'b1, STM_ADDR_CTRL0, 8'h89);
    rd10(STM_ADDR_CNT_HI, c);
    chk("below period", 32'h1, {31'h0, c < 10'd128});
    repeat (20) @(posedge core_clk);
    rd10(STM_ADDR_CNT_HI, c2);
    chk("paused", {22'h0, c}, {22'h0, c2});
    apb(1'b1, STM_ADDR_CTRL0, 8'h01);
    rd10(STM_ADDR_CNT_HI, c);
    repeat (20) @(posedge core_clk);
    rd10(STM_ADDR_CNT_HI, c2);
    chk("stopped", {22'h0, c}, {22'h0, c2});
    apb(1'b1, STM_ADDR_CTRL0, 8'h09);
    rd10(STM_ADDR_CNT_HI, c);
    chk("restart clear", 32'h1, {31'h0, c < 10'd4});
    $display("period test done");
    apb(1'b1, STM_ADDR_CTRL0, 8'h00);
    wr10(10'h000);
    restart(8'h00, 8'h08);
    repeat (1100) @(posedge core_clk);
    apb(1'b0, STM_ADDR_STATUS, 8'h00);
    chk("overflow flags", 32'h2, rd);
    apb(1'b1, STM_ADDR_CTRL1, 8'hCC);
    @(negedge core_clk);
    chk("timer mode pin", 32'h0, {31'h0, pin});
    chk("timer mode pin_n", 32'h1, {31'h0, pin_n});
    $display("overflow test done");
    for (int k = 0; k < 4; k++) begin
      restart({2'b10, 1'b0, k[0], k[1], 3'b000}, 8'h08);
      @(negedge core_clk);
      chk("pwm forced pin", {31'h0, k[0] == k[1]}, {31'h0, pin});
    end
    apb(1'b1, STM_ADDR_CTRL0, 8'h00);
    wr10(10'h020);
    restart(8'hA8, 8'h09);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("pwm active", 32'h1, {31'h0, pin});
    repeat (60) @(posedge core_clk);
    @(negedge core_clk);
    chk("pwm inactive", 32'h0, {31'h0, pin});
    $display("pwm test done");
    for (int k = 0; k < 4; k++) begin
      restart({2'b01, 2'(k), 4'h0}, 8'h08);
      for (int e = 0; e < 2; e++) begin
        @(posedge core_clk);
        cap_pin <= (e == 0);
        repeat (3) @(posedge core_clk);
        apb(1'b0, STM_ADDR_STATUS, 8'h00);
        chk("capture", {31'h0, cap_hit(2'(k), e == 0)}, {31'h0, rd[0]});
        apb(1'b1, STM_ADDR_STATUS, 8'h03);
      end
    end
    $display("capture test done");
    finish_test();
  end
endmodule : tb
